// file: shared/esmr_params.svh
// constants for the equalizer / strap / audio clock register group
// assumes an 8-bit register address space reached over the control bus
`ifndef ESMR_PARAMS_SVH
`define ESMR_PARAMS_SVH

// ==========================================================
// register offsets
`define ESMR_OFS_EQ_CTRL      8'h35
`define ESMR_OFS_STRAP        8'h37
`define ESMR_OFS_ACLK_DIV     8'h3a
`define ESMR_OFS_DUAL_RX      8'h34

// ==========================================================
// field positions
`define ESMR_EQ_RESTART_BIT   6
`define ESMR_EQ_FLOOR_OV_BIT  5
`define ESMR_EQ_FLOOR_ST_BIT  4
`define ESMR_BC_LATCHED_BIT   7
`define ESMR_BC_CODE_MSB      6
`define ESMR_BC_CODE_LSB      4
`define ESMR_OUT_LATCHED_BIT  3
`define ESMR_OUT_CODE_MSB     2
`define ESMR_OUT_CODE_LSB     0
`define ESMR_MDIV_OV_BIT      7
`define ESMR_MDIV_MSB         6
`define ESMR_MDIV_LSB         4
`define ESMR_MSEL_OV_BIT      2
`define ESMR_MSEL_MSB         1
`define ESMR_MSEL_LSB         0
`define ESMR_SECOND_PORT_SELECT_BIT    1

// ==========================================================
// reset values and masks of writable bits
`define ESMR_RST_EQ_CTRL      8'h00
`define ESMR_RST_STRAP        8'h00
`define ESMR_RST_ACLK_DIV     8'h00
`define ESMR_WMASK_EQ_CTRL    8'h70
`define ESMR_WMASK_ACLK_DIV   8'hf7

// ==========================================================
// strap sampling delay after reset release
`define ESMR_STRAP_SETTLE_NS  64
`define ESMR_CLK_PERIOD_NS    8
`endif

// file: shared/esmr_pkg.sv
// types shared by the register group and its strap decoder
// assumes esmr_params.svh sits beside it
package esmr_pkg;
    // ==========================================================
    // per-port equalizer controls
    typedef struct packed {
        logic restart;
        logic floor_override;
        logic floor_start;
    } esmr_eq_ctrl_t;

    // ==========================================================
    // decoded divider ratios (log2 of divisor)
    typedef struct packed {
        logic [2:0] vco_out_log2;
        logic [1:0] vco_in_log2;
        logic       vco_out_div_override;
        logic       vco_in_div_override;
    } esmr_div_t;

    // ==========================================================
    // strap capture sequence
    typedef enum logic [1:0] {
        ESMR_ST_WAIT   = 2'b00,
        ESMR_ST_SAMPLE = 2'b01,
        ESMR_ST_DONE   = 2'b10
    } esmr_strap_state_t;
endpackage

// file: verilog/esmr_strap_capture.sv
// captures the two multi-level strap decodes once after reset
// assumes strap codes from the analog level decoder are steady and sync
`include "esmr_params.svh"
module esmr_strap_capture #(
    parameter int SETTLE_CYCLES = (`ESMR_STRAP_SETTLE_NS
                                   + `ESMR_CLK_PERIOD_NS - 1)
                                  / `ESMR_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    // raw decodes from the strap pins
    input  wire logic [2:0] bc_strap_level_in,
    input  wire logic [2:0] out_strap_level_in,
    // latched results
    output logic            bc_latched_out,
    output logic [2:0]      bc_code_out,
    output logic            out_latched_out,
    output logic [2:0]      out_code_out
);
    esmr_pkg::esmr_strap_state_t state_r;
    logic [7:0]                  cnt_r;

    // ==========================================================
    // settle, sample once, then hold
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= esmr_pkg::ESMR_ST_WAIT;
            cnt_r   <= 8'h00;
        end else begin
            case (state_r)
                esmr_pkg::ESMR_ST_WAIT: begin
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r >= 8'(SETTLE_CYCLES - 1)) begin
                        state_r <= esmr_pkg::ESMR_ST_SAMPLE;
                    end
                end
                esmr_pkg::ESMR_ST_SAMPLE: state_r <= esmr_pkg::ESMR_ST_DONE;
                esmr_pkg::ESMR_ST_DONE:   state_r <= esmr_pkg::ESMR_ST_DONE;
                default:                  state_r <= esmr_pkg::ESMR_ST_WAIT;
            endcase
        end
    end

    // ==========================================================
    // codes and flags stay zero until the sample cycle
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bc_code_out     <= 3'h0;
            out_code_out    <= 3'h0;
            bc_latched_out  <= 1'b0;
            out_latched_out <= 1'b0;
        end else if (state_r == esmr_pkg::ESMR_ST_SAMPLE) begin
            bc_code_out     <= bc_strap_level_in;
            out_code_out    <= out_strap_level_in;
            bc_latched_out  <= 1'b1;
            out_latched_out <= 1'b1;
        end
    end
endmodule // esmr_strap_capture

// file: verilog/esmr_regs.sv
// equalizer test, strap status and audio clock divider registers
// assumes a byte-wide register port from the control bus target logic,
// with one-cycle write and read strobes synchronous to clk_sys_in
`include "esmr_params.svh"

module esmr_regs (
    // clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    // register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    // port select from the dual receive control register
    input  wire logic       second_port_select_in,
    // strap pin decodes
    input  wire logic [2:0] bc_strap_level_in,
    input  wire logic [2:0] out_strap_level_in,
    // ratios proposed by the pll state machine
    input  wire logic [1:0] pll_state_machine_in_log2_in,
    input  wire logic [2:0] pll_state_machine_out_log2_in,
    // equalizer controls, one set per receive port
    output esmr_pkg::esmr_eq_ctrl_t eq_port0_out,
    output esmr_pkg::esmr_eq_ctrl_t eq_port1_out,
    // strap results
    output logic [2:0]      bc_strap_code_out,
    output logic [2:0]      out_strap_code_out,
    // divider controls toward the audio clock pll
    output esmr_pkg::esmr_div_t div_out
);
    // ==========================================================
    // storage
    logic [7:0] eq_ctrl_p0_r;
    logic [7:0] eq_ctrl_p1_r;
    logic       restart_r;
    logic [7:0] aclk_div_r;
    logic       bc_latched;
    logic [2:0] bc_code;
    logic       out_latched;
    logic [2:0] out_code;
    logic [7:0] rdata_nxt;

    // vco output divide code to log2 of divisor
    function automatic logic [2:0] esmr_mdiv_log2(input logic [2:0] code);
        case (code)
            3'h0:    esmr_mdiv_log2 = 3'h5;
            3'h1:    esmr_mdiv_log2 = 3'h4;
            3'h2:    esmr_mdiv_log2 = 3'h3;
            3'h3:    esmr_mdiv_log2 = 3'h2;
            3'h4,
            3'h5:    esmr_mdiv_log2 = 3'h1;
            default: esmr_mdiv_log2 = 3'h0;
        endcase
    endfunction

    // register hit test
    function automatic logic esmr_hit(input logic [7:0] a,
                                      input logic [7:0] ofs);
        esmr_hit = (a == ofs);
    endfunction

    // ==========================================================
    // per-port equalizer test bits, steered by port select
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            eq_ctrl_p0_r <= `ESMR_RST_EQ_CTRL;
            eq_ctrl_p1_r <= `ESMR_RST_EQ_CTRL;
        end else if (reg_wr_in &&
                     esmr_hit(reg_addr_in, `ESMR_OFS_EQ_CTRL)) begin
            if (second_port_select_in) begin
                eq_ctrl_p1_r <= reg_wdata_in & `ESMR_WMASK_EQ_CTRL;
            end else begin
                eq_ctrl_p0_r <= reg_wdata_in & `ESMR_WMASK_EQ_CTRL;
            end
        end
    end

    // ==========================================================
    // restart is a shared bit: one store drives both ports
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            restart_r <= 1'b0;
        end else if (reg_wr_in &&
                     esmr_hit(reg_addr_in, `ESMR_OFS_EQ_CTRL)) begin
            restart_r <= reg_wdata_in[`ESMR_EQ_RESTART_BIT];
        end
    end

    // ==========================================================
    // audio clock divider select, shared between ports
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            aclk_div_r <= `ESMR_RST_ACLK_DIV;
        end else if (reg_wr_in &&
                     esmr_hit(reg_addr_in, `ESMR_OFS_ACLK_DIV)) begin
            aclk_div_r <= reg_wdata_in & `ESMR_WMASK_ACLK_DIV;
        end
    end

    // ==========================================================
    // strap capture
    esmr_strap_capture u_strap (
        .clk_sys_in         (clk_sys_in),
        .reset_in           (reset_in),
        .bc_strap_level_in  (bc_strap_level_in),
        .out_strap_level_in (out_strap_level_in),
        .bc_latched_out     (bc_latched),
        .bc_code_out        (bc_code),
        .out_latched_out    (out_latched),
        .out_code_out       (out_code)
    );

    // ==========================================================
    // equalizer control outputs
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            eq_port0_out <= '0;
            eq_port1_out <= '0;
        end else begin
            eq_port0_out.restart <= restart_r;
            eq_port1_out.restart <= restart_r;
            eq_port0_out.floor_override <=
                eq_ctrl_p0_r[`ESMR_EQ_FLOOR_OV_BIT];
            eq_port1_out.floor_override <=
                eq_ctrl_p1_r[`ESMR_EQ_FLOOR_OV_BIT];
            // floor start is gated by its override
            eq_port0_out.floor_start <=
                eq_ctrl_p0_r[`ESMR_EQ_FLOOR_OV_BIT] &
                eq_ctrl_p0_r[`ESMR_EQ_FLOOR_ST_BIT];
            eq_port1_out.floor_start <=
                eq_ctrl_p1_r[`ESMR_EQ_FLOOR_OV_BIT] &
                eq_ctrl_p1_r[`ESMR_EQ_FLOOR_ST_BIT];
        end
    end

    // ==========================================================
    // divider outputs: register value under override, else state machine
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            div_out <= '0;
        end else begin
            div_out.vco_out_div_override <= aclk_div_r[`ESMR_MDIV_OV_BIT];
            div_out.vco_in_div_override  <= aclk_div_r[`ESMR_MSEL_OV_BIT];
            if (aclk_div_r[`ESMR_MDIV_OV_BIT]) begin
                div_out.vco_out_log2 <= esmr_mdiv_log2(
                    aclk_div_r[`ESMR_MDIV_MSB:`ESMR_MDIV_LSB]);
            end else begin
                div_out.vco_out_log2 <= pll_state_machine_out_log2_in;
            end
            if (aclk_div_r[`ESMR_MSEL_OV_BIT]) begin
                // code equals log2 of 1,2,4,8
                div_out.vco_in_log2 <=
                    aclk_div_r[`ESMR_MSEL_MSB:`ESMR_MSEL_LSB];
            end else begin
                div_out.vco_in_log2 <= pll_state_machine_in_log2_in;
            end
        end
    end

    // ==========================================================
    // strap code outputs
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bc_strap_code_out  <= 3'h0;
            out_strap_code_out <= 3'h0;
        end else begin
            bc_strap_code_out  <= bc_code;
            out_strap_code_out <= out_code;
        end
    end

    // ==========================================================
    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (esmr_hit(reg_addr_in, `ESMR_OFS_EQ_CTRL)) begin
            rdata_nxt = second_port_select_in ? eq_ctrl_p1_r
                                              : eq_ctrl_p0_r;
            rdata_nxt[`ESMR_EQ_RESTART_BIT] = restart_r;
        end else if (esmr_hit(reg_addr_in, `ESMR_OFS_STRAP)) begin
            rdata_nxt = {bc_latched, bc_code,
                         out_latched, out_code};
        end else if (esmr_hit(reg_addr_in, `ESMR_OFS_ACLK_DIV)) begin
            rdata_nxt = aclk_div_r;
        end
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_nxt;
            end
        end
    end
endmodule // esmr_regs

// file: bench/esmr_regs_props.sv
// concurrent checks on the register group ports
// assumes bound onto esmr_regs, single clock domain
module esmr_regs_props (
    // clock and reset
    input wire logic                    clk_sys_in,
    input wire logic                    reset_in,
    // register port
    input wire logic [7:0]              reg_addr_in,
    input wire logic [7:0]              reg_wdata_in,
    input wire logic                    reg_wr_in,
    input wire logic                    reg_rd_in,
    input wire logic [7:0]              reg_rdata_out,
    input wire logic                    reg_rvalid_out,
    // side inputs
    input wire logic                    second_port_select_in,
    input wire logic [2:0]              bc_strap_level_in,
    input wire logic [2:0]              out_strap_level_in,
    input wire logic [1:0]              pll_state_machine_in_log2_in,
    // outputs under watch
    input wire esmr_pkg::esmr_eq_ctrl_t eq_port0_out,
    input wire esmr_pkg::esmr_eq_ctrl_t eq_port1_out,
    input wire logic [2:0]              bc_strap_code_out,
    input wire logic [2:0]              out_strap_code_out,
    input wire esmr_pkg::esmr_div_t     div_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    logic [3:0] cnt_r;

    // =========================================================
    // helpers
    // cycles since reset release, saturating
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) cnt_r <= 4'h0;
        else if (cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
    end
    function automatic logic [2:0] out_log2(input logic [2:0] c);
        return c[2] ? {2'b00, ~c[1]} : 3'h5 - c;
    endfunction
    sequence s_eq_wr;
        reg_wr_in && reg_addr_in == 8'h35;
    endsequence
    sequence s_div_wr;
        reg_wr_in && reg_addr_in == 8'h3a;
    endsequence
    sequence s_strap_rd;
        reg_rvalid_out && $past(reg_rd_in) && $past(reg_addr_in) == 8'h37;
    endsequence

    // =========================================================
    // properties
    property p_restart;
        s_eq_wr |-> ##2 eq_port0_out.restart == $past(reg_wdata_in[6], 2);
    endproperty
    property p_both;
        eq_port0_out.restart == eq_port1_out.restart;
    endproperty
    property p_floor;
        (eq_port0_out.floor_start |-> eq_port0_out.floor_override) and
        (eq_port1_out.floor_start |-> eq_port1_out.floor_override);
    endproperty
    property p_port1;
        s_eq_wr ##0 second_port_select_in |-> ##2
            eq_port1_out.floor_start == $past(&reg_wdata_in[5:4], 2);
    endproperty
    property p_strap_zero;
        cnt_r < 4'h8 |-> bc_strap_code_out == 3'h0 &&
            out_strap_code_out == 3'h0;
    endproperty
    property p_bc_rd;
        s_strap_rd |-> reg_rdata_out[6:4] ==
            (reg_rdata_out[7] ? bc_strap_level_in : 3'h0);
    endproperty
    property p_out_rd;
        s_strap_rd |-> reg_rdata_out[2:0] ==
            (reg_rdata_out[3] ? out_strap_level_in : 3'h0);
    endproperty
    property p_mdiv;
        s_div_wr ##0 reg_wdata_in[7] |-> ##2 div_out.vco_out_div_override
            && div_out.vco_out_log2 == out_log2($past(reg_wdata_in[6:4], 2));
    endproperty
    property p_msel;
        s_div_wr ##0 reg_wdata_in[2] |-> ##2
            div_out.vco_in_log2 == $past(reg_wdata_in[1:0], 2);
    endproperty
    // skip the first edge after release: outputs still hold reset zeros
    property p_sm;
        cnt_r != 4'h0 && !div_out.vco_in_div_override &&
            $stable(pll_state_machine_in_log2_in) |->
            div_out.vco_in_log2 == pll_state_machine_in_log2_in;
    endproperty

    a_restart: assert property (p_restart)
        else $error("restart lost");
    a_both: assert property (p_both)
        else $error("restart split");
    a_floor: assert property (p_floor)
        else $error("floor ungated");
    a_port1: assert property (p_port1)
        else $error("port1 floor");
    a_strap_zero: assert property (p_strap_zero)
        else $error("early");
    a_bc_rd: assert property (p_bc_rd)
        else $error("bc strap read");
    a_out_rd: assert property (p_out_rd)
        else $error("out strap");
    a_mdiv: assert property (p_mdiv)
        else $error("vco out div");
    a_msel: assert property (p_msel)
        else $error("vco in div");
    a_sm: assert property (p_sm)
        else $error("state machine div");
endmodule // esmr_regs_props

bind esmr_regs esmr_regs_props esmr_regs_props_inst (
    .clk_sys_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .second_port_select_in,
    .bc_strap_level_in, .out_strap_level_in, .pll_state_machine_in_log2_in,
    .eq_port0_out, .eq_port1_out, .bc_strap_code_out,
    .out_strap_code_out, .div_out
);

// file: bench/esmr_host_model.sv
// host side of the byte-wide register port
// assumes one-cycle strobes and a registered read answer
module esmr_host_model (
    // clock
    input  wire logic       clk_sys_in,
    // register port toward the block
    output logic [7:0]      reg_addr_out,
    output logic [7:0]      reg_wdata_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
    end
    // one write, released lines flip
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask
    // one read, bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge clk_sys_in);
            ok = (reg_rvalid_in === 1'b1);
            d = reg_rdata_in;
        end
    endtask
endmodule // esmr_host_model

// file: bench/tb_top.sv
// self-checking bench for the register group
// assumes the host model and the bound checker
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic sel = 1'b0;
    logic [1:0] pll_in = 2'b10;
    logic [2:0] pll_out = 3'b101;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic [2:0] bc_code, out_code;
    esmr_pkg::esmr_eq_ctrl_t eq0, eq1;
    esmr_pkg::esmr_div_t div;
    int n_fail = 0;
    int num_checks = 0;
    localparam logic [2:0] BC = 3'b110;
    localparam logic [2:0] OUTS = 3'b011;

    // =========================================================
    // clock and instances
    always #4 clk_sys_in = ~clk_sys_in;
    esmr_host_model esmr_host_model_inst (.clk_sys_in(clk_sys_in),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
    esmr_regs esmr_regs_inst (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .second_port_select_in(sel),
        .bc_strap_level_in(BC), .out_strap_level_in(OUTS),
        .pll_state_machine_in_log2_in(pll_in), .pll_state_machine_out_log2_in(pll_out),
        .eq_port0_out(eq0), .eq_port1_out(eq1),
        .bc_strap_code_out(bc_code), .out_strap_code_out(out_code),
        .div_out(div));

    // =========================================================
    // shared tasks
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input string what);
        logic [7:0] d;
        logic ok;
        esmr_host_model_inst.rd(a, d, ok);
        check("rvalid", {7'h00, ok}, 8'h01);
        check(what, d, exp);
    endtask
    task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
        esmr_host_model_inst.wr(a, d);
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic t_reset_vals();
        rd_chk(8'h37, 8'h00, "strap early");
        rd_chk(8'h35, 8'h00, "eq reset");
        rd_chk(8'h3a, 8'h00, "div reset");
        repeat (12) @(posedge clk_sys_in);
        rd_chk(8'h37, {1'b1, BC, 1'b1, OUTS},
               "strap");
        check("bc code", {5'h00, bc_code}, {5'h00, BC});
        check("out code", {5'h00, out_code}, {5'h00, OUTS});
    endtask
    task automatic t_eq();
        wr_settle(8'h35, 8'hff);
        check("eq0", {5'h00, eq0}, 8'h07);
        check("eq1", {5'h00, eq1}, 8'h04);
        rd_chk(8'h35, 8'h70, "eq rd");
        // port select changes on a clock edge, like every input
        @(posedge clk_sys_in);
        sel <= 1'b1;
        wr_settle(8'h35, 8'h10);
        check("eq1 ungated", {5'h00, eq1}, 8'h00);
        check("eq0 kept", {5'h00, eq0}, 8'h03);
        rd_chk(8'h35, 8'h10, "eq rd port1");
        wr_settle(8'h35, 8'h30);
        check("eq1 floor", {5'h00, eq1}, 8'h03);
        wr_settle(8'h35, 8'h60);
        check("eq1 ov", {5'h00, eq1}, 8'h06);
        @(posedge clk_sys_in);
        sel <= 1'b0;
        rd_chk(8'h35, 8'h70, "eq rd port0");
    endtask
    task automatic t_div();
        logic [2:0] tab [8];
        tab = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
        for (int c = 0; c < 8; c++) begin
            wr_settle(8'h3a, {1'b1, c[2:0], 2'b01, c[1:0]});
            check("div ov", {1'b0, div},
                  {1'b0, tab[c], c[1:0], 2'b11});
        end
        rd_chk(8'h3a, 8'hf7, "div rd");
        wr_settle(8'h3a, 8'h05);
        check("div in", {1'b0, div},
              {1'b0, pll_out, 2'b01, 2'b01});
        wr_settle(8'h3a, 8'h70);
        check("div sm", {1'b0, div},
              {1'b0, pll_out, pll_in, 2'b00});
        // new state machine ratios must pass straight through
        @(posedge clk_sys_in);
        pll_in <= 2'b01;
        pll_out <= 3'b011;
        repeat (2) @(posedge clk_sys_in);
        #1;
        check("div pll", {1'b0, div}, 8'h34);
        esmr_host_model_inst.wr(8'h37, 8'h00);
        wr_settle(8'h36, 8'hff);
        rd_chk(8'h36, 8'h00, "unmapped");
        rd_chk(8'h37, {1'b1, BC, 1'b1, OUTS}, "strap ro");
    endtask

    // =========================================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        t_reset_vals();
        t_eq();
        t_div();
        wrap_up();
    end
    initial begin
        repeat (4000) @(posedge clk_sys_in);
        n_fail++;
        wrap_up();
    end
endmodule // tb_top
